// File: logic/nsov_relay.sv
// Purpose: definite-time negative-sequence overvoltage relay
// Assumes: magnitudes arrive from logic on the same clock
// Notes: 16-bit register port, read data one cycle late
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "nsov_map.svh"

// Operation
// - derive negative-sequence magnitude from three phases
// - start when above percent start level
// - count millisecond delay while started
// - trip only after full uninterrupted delay
// - start-only setting suppresses general trip
// - decision combines start, trip, option, block
// - block input forces both outputs low
// - mode off disables the function
// - trip needs expiry and tripping selected
module nsov_relay #(
    parameter int MS_CYC = `NSOV_MS_NS / `NSOV_CLK_NS
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic [15:0] I_PH1_MAG,
    input wire logic [15:0] I_PH2_MAG,
    input wire logic [15:0] I_PH3_MAG,
    input wire logic I_FUNC_BLOCK,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    output logic O_GEN_START,
    output logic O_GEN_TRIP,
    output logic O_IRQ
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------

    // magnitude-only estimate: spread of phases / 3
    // exact only with phase angles; this is the
    // cheap imbalance measure we can afford here
    // one phase off by d from the others gives d / 3
    function automatic logic [15:0] neg_seq(
        input logic [15:0] a,
        input logic [15:0] b,
        input logic [15:0] c
    );
        logic [15:0] mx;
        logic [15:0] mn;
        logic [31:0] prod;
        mx = a;
        mn = a;
        if (b > mx) begin
            mx = b;
        end
        if (c > mx) begin
            mx = c;
        end
        if (b < mn) begin
            mn = b;
        end
        if (c < mn) begin
            mn = c;
        end
        // times 21846 / 65536 is one third
        prod = 32'(mx - mn) * 32'h5556;
        return prod[31:16];
    endfunction

    // hold a written setting inside its range
    function automatic logic [15:0] clamp(
        input logic [15:0] v,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam nsov_pkg::nsov_regs_t RST_VAL = '{
        mode: 1'b0,
        sonly: 1'b0,
        level: `NSOV_LEVEL_RST,
        delay: `NSOV_DELAY_RST,
        nom: `NSOV_NOM_RST,
        neg: 16'h0,
        above: 1'b0,
        st: nsov_pkg::ST_IDLE,
        pre: 14'h0,
        ms: 16'h0,
        ist: 2'h0,
        imsk: 2'h0,
        gst: 1'b0,
        gtr: 1'b0,
        irq: 1'b0,
        rdata: 16'h0
    };

    nsov_pkg::nsov_regs_t s_q; // registered state
    nsov_pkg::nsov_regs_t s_d; // next state
    logic enabled; // mode on and not blocked
    logic tick; // one-cycle 1 ms enable
    logic [23:0] lhs; // neg magnitude times 100
    logic [23:0] rhs; // level percent times nominal
    logic [15:0] lvl16; // clamped level write

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------

    // one process computes everything
    always_comb begin
        s_d = s_q;
        lvl16 = clamp(I_WDATA, `NSOV_LEVEL_MIN, `NSOV_LEVEL_MAX);

        // preparatory stage, one cycle of latency
        s_d.neg = neg_seq(I_PH1_MAG, I_PH2_MAG, I_PH3_MAG);

        // percent compare without a divider
        // widest product is 0xffff * 100, well inside 24 bits
        lhs = 24'(s_q.neg) * 24'h64;
        rhs = 24'(s_q.level) * 24'(s_q.nom);
        s_d.above = lhs > rhs;

        // function off or blocked
        enabled = s_q.mode && !I_FUNC_BLOCK;

        // millisecond divider runs only while timing
        // the 14-bit prescaler caps MS_CYC at 16384
        tick = s_q.pre == 14'(MS_CYC - 1);

        // definite-time characteristic
        unique case (s_q.st)
            nsov_pkg::ST_IDLE: begin
                s_d.pre = 14'h0;
                s_d.ms = 16'h0;
                if (s_q.above) begin
                    s_d.st = nsov_pkg::ST_TIMING;
                end
            end
            nsov_pkg::ST_TIMING: begin
                if (tick) begin
                    // count elapsed milliseconds
                    s_d.pre = 14'h0;
                    s_d.ms = s_q.ms + 16'h1;
                    if (s_q.ms + 16'h1 >= s_q.delay) begin
                        s_d.st = nsov_pkg::ST_TRIPPED;
                    end
                end else begin
                    s_d.pre = s_q.pre + 14'h1;
                end
            end
            nsov_pkg::ST_TRIPPED: begin
                // hold until the voltage drops
                s_d.pre = 14'h0;
            end
        endcase

        // drop-out or disable restarts the timer
        // placed after the case so it overrides any state move
        if (!s_q.above || !enabled) begin
            s_d.st = nsov_pkg::ST_IDLE;
            s_d.pre = 14'h0;
            s_d.ms = 16'h0;
        end

        // decision logic
        s_d.gst = enabled && s_q.st != nsov_pkg::ST_IDLE;
        s_d.gtr = enabled && !s_q.sonly
            && s_q.st == nsov_pkg::ST_TRIPPED;

        // sticky events; a set beats a clear
        // the clear goes first so a same-cycle set survives
        if (I_WR && I_ADDR == `NSOV_ADR_ISTAT) begin
            s_d.ist = s_q.ist & ~I_WDATA[1:0];
        end
        if (s_d.gst && !s_q.gst) begin
            s_d.ist[`NSOV_EV_START] = 1'b1;
        end
        if (s_d.gtr && !s_q.gtr) begin
            s_d.ist[`NSOV_EV_TRIP] = 1'b1;
        end
        s_d.irq = |(s_q.ist & s_q.imsk);

        // register writes
        // settings out of range are pulled to the nearest limit
        if (I_WR) begin
            unique case (I_ADDR)
                `NSOV_ADR_CTRL: begin
                    s_d.mode = I_WDATA[`NSOV_CTRL_MODE];
                    s_d.sonly = I_WDATA[`NSOV_CTRL_SONLY];
                end
                `NSOV_ADR_LEVEL: begin
                    s_d.level = lvl16[5:0];
                end
                `NSOV_ADR_DELAY: begin
                    s_d.delay = clamp(I_WDATA, `NSOV_DELAY_MIN,
                        `NSOV_DELAY_MAX);
                end
                `NSOV_ADR_NOM: begin
                    s_d.nom = I_WDATA;
                end
                `NSOV_ADR_IMASK: begin
                    s_d.imsk = I_WDATA[1:0];
                end
                default: begin
                    // read-only, unmapped or ISTAT (cleared above): no setting changes
                end
            endcase
        end

        // read data stand one cycle only
        // idle zero keeps an or-ed read bus quiet
        s_d.rdata = 16'h0;
        if (I_RD) begin
            unique case (I_ADDR)
                `NSOV_ADR_CTRL: begin
                    s_d.rdata = {14'h0, s_q.sonly, s_q.mode};
                end
                `NSOV_ADR_LEVEL: begin
                    s_d.rdata = {10'h0, s_q.level};
                end
                `NSOV_ADR_DELAY: begin
                    s_d.rdata = s_q.delay;
                end
                `NSOV_ADR_NOM: begin
                    s_d.rdata = s_q.nom;
                end
                `NSOV_ADR_STAT: begin
                    // live state of the relay
                    s_d.rdata = {12'h0, s_q.gtr, s_q.gst,
                        s_q.st == nsov_pkg::ST_TRIPPED, s_q.above};
                end
                `NSOV_ADR_NEG: begin
                    s_d.rdata = s_q.neg;
                end
                `NSOV_ADR_ISTAT: begin
                    s_d.rdata = {14'h0, s_q.ist};
                end
                `NSOV_ADR_IMASK: begin
                    s_d.rdata = {14'h0, s_q.imsk};
                end
                default: begin
                    // unmapped reads as zero
                    s_d.rdata = 16'h0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------

    // synchronous reset to constants
    // settings return to defaults with the function off
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            s_q <= RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign O_GEN_START = s_q.gst;
    assign O_GEN_TRIP = s_q.gtr;
    assign O_IRQ = s_q.irq;
    assign O_RDATA = s_q.rdata;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // one clock domain; checks sleep while reset is high
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RESET);

    AST_NEG_PIPE: assert property (
        s_q.neg == $past(neg_seq(I_PH1_MAG, I_PH2_MAG, I_PH3_MAG)))
        else $error("neg magnitude not taken from phases");

    AST_START_CAUSE: assert property (
        $rose(O_GEN_START) |-> $past(s_q.above, 2))
        else $error("start without overvoltage");

    AST_NO_EARLY_TRIP: assert property (
        s_q.st == nsov_pkg::ST_TRIPPED |-> s_q.ms >= s_q.delay)
        else $error("trip before delay elapsed");

    AST_MS_STEP: assert property (
        s_q.st == nsov_pkg::ST_TIMING && tick && s_q.above && enabled
        |=> s_q.ms == $past(s_q.ms) + 16'h1)
        else $error("millisecond count did not step");

    AST_START_ONLY: assert property (
        s_q.sonly |=> !O_GEN_TRIP)
        else $error("trip while start only");

    AST_TRIP_HAS_START: assert property (
        O_GEN_TRIP |-> O_GEN_START)
        else $error("trip without start");

    AST_START_EVENT: assert property (
        $rose(O_GEN_START) |-> s_q.ist[`NSOV_EV_START])
        else $error("start event not latched");

    AST_BLOCK: assert property (
        I_FUNC_BLOCK |=> !O_GEN_START && !O_GEN_TRIP)
        else $error("output while blocked");

    AST_MODE_OFF: assert property (
        !s_q.mode |=> !O_GEN_START)
        else $error("start while mode off");

    AST_TRIP_CAUSE: assert property (
        $rose(O_GEN_TRIP) |-> $past(s_q.st) == nsov_pkg::ST_TRIPPED
        && !$past(s_q.sonly))
        else $error("trip without expired delay");

    AST_DROP_OUT: assert property (
        !s_q.above |=> s_q.st == nsov_pkg::ST_IDLE && s_q.ms == 16'h0)
        else $error("drop-out did not clear timer");

    // main scenarios the bench must reach
    CV_TRIP: cover property ($rose(O_GEN_TRIP));
    CV_DROP_TIMING: cover property (
        s_q.st == nsov_pkg::ST_TIMING ##1 s_q.st == nsov_pkg::ST_IDLE);
    CV_BLOCK_TRIP: cover property (O_GEN_TRIP ##1 I_FUNC_BLOCK);
    CV_IRQ: cover property ($rose(O_IRQ));
    CV_START_ONLY: cover property (
        s_q.sonly && s_q.st == nsov_pkg::ST_TRIPPED && O_GEN_START);

endmodule

// File: logic/nsov_map.svh
// Purpose: constants for the negative-sequence overvoltage relay
// Assumes: 10 MHz processing clock
// Notes: offsets are word indices on the plain register port
`ifndef NSOV_MAP_SVH
`define NSOV_MAP_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define NSOV_ADR_CTRL 4'h0
`define NSOV_ADR_LEVEL 4'h1
`define NSOV_ADR_DELAY 4'h2
`define NSOV_ADR_NOM 4'h3
`define NSOV_ADR_STAT 4'h4
`define NSOV_ADR_NEG 4'h5
`define NSOV_ADR_ISTAT 4'h6
`define NSOV_ADR_IMASK 4'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define NSOV_CTRL_MODE 0
`define NSOV_CTRL_SONLY 1
`define NSOV_EV_START 0
`define NSOV_EV_TRIP 1

// ----------------------------------------
// reset values and setting limits
// ----------------------------------------
`define NSOV_LEVEL_RST 6'h1e
`define NSOV_LEVEL_MIN 16'h0002
`define NSOV_LEVEL_MAX 16'h0028
`define NSOV_DELAY_RST 16'h0064
`define NSOV_DELAY_MIN 16'h0032
`define NSOV_DELAY_MAX 16'hea60
`define NSOV_NOM_RST 16'h1000

// ----------------------------------------
// timing
// ----------------------------------------
`define NSOV_MS_NS 1000000
`define NSOV_CLK_NS 100

`endif

// File: logic/nsov_pkg.sv
// Purpose: types of the negative-sequence overvoltage relay
// Assumes: nothing
// Notes: all relay state lives in one packed struct
package nsov_pkg;

    // one-hot characteristic states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_TIMING = 3'h2,
        ST_TRIPPED = 3'h4
    } nsov_state_t;

    // complete register state of the relay
    typedef struct packed {
        logic mode;
        logic sonly;
        logic [5:0] level;
        logic [15:0] delay;
        logic [15:0] nom;
        logic [15:0] neg;
        logic above;
        nsov_state_t st;
        logic [13:0] pre;
        logic [15:0] ms;
        logic [1:0] ist;
        logic [1:0] imsk;
        logic gst;
        logic gtr;
        logic irq;
        logic [15:0] rdata;
    } nsov_regs_t;

endpackage

// File: sim/nsov_source_model.sv
// Purpose: upstream magnitude stage feeding the relay
// Assumes: same clock as the relay, values move just after an edge
// Notes: phase 1 carries the imbalance, phases 2 and 3 sit at base
`timescale 1ns/1ps

module nsov_source_model (
    input wire logic i_clk,
    input wire logic [15:0] i_base,
    input wire logic [15:0] i_skew,
    output logic [15:0] o_ph1,
    output logic [15:0] o_ph2,
    output logic [15:0] o_ph3
);
    // --------------------------------
    // registered magnitudes
    // --------------------------------
    // registered so a change lands one edge late, like a real filter output
    always_ff @(posedge i_clk) begin
        o_ph1 <= i_base + i_skew;
        o_ph2 <= i_base;
        o_ph3 <= i_base;
    end
endmodule

// File: sim/test_nsov_relay.sv
// Purpose: self-checking bench of the negative-sequence relay
// Assumes: millisecond shortened to 4 cycles
// Notes: only mismatches and the verdict are printed
`timescale 1ns/1ps
`include "nsov_map.svh"

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_nsov_relay;
    // --------------------------------
    // signals
    // --------------------------------
    localparam int MS_CYC = 4; // short millisecond keeps runs brief
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic blk = 1'b0; // function block input
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] base = 16'h2000;
    logic [15:0] skew = 16'h0000;
    logic [15:0] ph1, ph2, ph3, rdata;
    logic gst, gtr, irq;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    nsov_source_model src (
        .i_clk(clk), .i_base(base), .i_skew(skew),
        .o_ph1(ph1), .o_ph2(ph2), .o_ph3(ph3)
    );

    nsov_relay #(.MS_CYC(MS_CYC)) uut (
        .I_REF_CLK(clk), .I_RESET(rst),
        .I_PH1_MAG(ph1), .I_PH2_MAG(ph2), .I_PH3_MAG(ph3),
        .I_FUNC_BLOCK(blk), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(i_wr), .I_RD(i_rd), .O_RDATA(rdata),
        .O_GEN_START(gst), .O_GEN_TRIP(gtr), .O_IRQ(irq)
    );

    // --------------------------------
    // bus and helper tasks
    // --------------------------------
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        i_wr <= 1'b1;
        @(posedge clk);
        i_wr <= 1'b0;
    endtask

    // read data is only valid in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        i_rd <= 1'b1;
        @(posedge clk);
        i_rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // wait and settle past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // new phase magnitudes to the source
    task automatic mags(input logic [15:0] b, input logic [15:0] s);
        @(posedge clk);
        base <= b;
        skew <= s;
    endtask

    // verdict and end of run
    task automatic results();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // --------------------------------
    // hang guard
    // --------------------------------
    // whole sequence needs about 950 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            results();
        end
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        `CHK({gst, gtr, irq}, 3'b000)
        // reset values of the settings
        rdchk(`NSOV_ADR_CTRL, 16'h0000);
        rdchk(`NSOV_ADR_LEVEL, 16'h001e);
        rdchk(`NSOV_ADR_DELAY, 16'h0064);
        rdchk(`NSOV_ADR_NOM, 16'h1000);
        rdchk(`NSOV_ADR_IMASK, 16'h0000);
        rdchk(4'h8, 16'h0000);
        // imbalance of 0x1000 gives 0x555; function still off
        mags(16'h2000, 16'h1000);
        cyc(8);
        `CHK({gst, gtr}, 2'b00)
        rdchk(`NSOV_ADR_NEG, 16'h0555);
        // delay below range clamps to the minimum 50 ms
        wr(`NSOV_ADR_DELAY, 16'h000a);
        rdchk(`NSOV_ADR_DELAY, 16'h0032);
        wr(`NSOV_ADR_CTRL, 16'h0001);
        cyc(5);
        `CHK({gst, gtr}, 2'b10)
        cyc(185);
        `CHK({gst, gtr}, 2'b10)
        cyc(30);
        `CHK({gst, gtr}, 2'b11)
        // live status: trip, start, tripped state, above level
        rdchk(`NSOV_ADR_STAT, 16'h000f);
        rdchk(`NSOV_ADR_ISTAT, 16'h0003);
        // block while tripped drops both outputs
        @(posedge clk);
        blk <= 1'b1;
        cyc(2);
        `CHK({gst, gtr}, 2'b00)
        @(posedge clk);
        blk <= 1'b0;
        // balance drops out and the timer starts over
        mags(16'h2000, 16'h0000);
        cyc(6);
        `CHK({gst, gtr}, 2'b00)
        mags(16'h2000, 16'h1000);
        cyc(100);
        `CHK({gst, gtr}, 2'b10)
        // block input holds both outputs low
        @(posedge clk);
        blk <= 1'b1;
        cyc(3);
        `CHK({gst, gtr}, 2'b00)
        cyc(250);
        `CHK({gst, gtr}, 2'b00)
        @(posedge clk);
        blk <= 1'b0;
        cyc(5);
        `CHK({gst, gtr}, 2'b10)
        // start-only never trips
        wr(`NSOV_ADR_CTRL, 16'h0003);
        cyc(250);
        `CHK({gst, gtr}, 2'b10)
        // equal to the level is not above it
        wr(`NSOV_ADR_NOM, 16'h1554);
        wr(`NSOV_ADR_LEVEL, 16'h0019);
        wr(`NSOV_ADR_CTRL, 16'h0001);
        cyc(6);
        `CHK({gst, gtr}, 2'b00)
        wr(`NSOV_ADR_LEVEL, 16'h0001);
        rdchk(`NSOV_ADR_LEVEL, 16'h0002);
        wr(`NSOV_ADR_LEVEL, 16'h0019);
        cyc(6);
        `CHK({gst, gtr}, 2'b00)
        wr(`NSOV_ADR_LEVEL, 16'h0018);
        cyc(6);
        `CHK({gst, gtr}, 2'b10)
        wr(`NSOV_ADR_CTRL, 16'h0000);
        cyc(3);
        `CHK({gst, gtr}, 2'b00)
        // start event: sticky, masked, unmasked, cleared
        wr(`NSOV_ADR_ISTAT, 16'h0003);
        wr(`NSOV_ADR_CTRL, 16'h0001);
        cyc(6);
        `CHK(irq, 1'b0)
        rdchk(`NSOV_ADR_ISTAT, 16'h0001);
        wr(`NSOV_ADR_IMASK, 16'h0001);
        cyc(2);
        `CHK(irq, 1'b1)
        wr(`NSOV_ADR_ISTAT, 16'h0001);
        cyc(2);
        `CHK(irq, 1'b0)
        // settings above range pull to the maximum
        wr(`NSOV_ADR_LEVEL, 16'h003f);
        rdchk(`NSOV_ADR_LEVEL, 16'h0028);
        wr(`NSOV_ADR_DELAY, 16'hffff);
        rdchk(`NSOV_ADR_DELAY, 16'hea60);
        results();
    end
endmodule
